// *** hw/clkgen_params.svh ***
`ifndef CLKGEN_PARAMS_SVH
`define CLKGEN_PARAMS_SVH

// Register byte offsets
`define OFS_SYS_CFG 8'h00
`define OFS_PLL_CFG 8'h04
`define OFS_PRE_CFG 8'h08
`define OFS_STATUS 8'h0C

// Field widths
`define PRE_W 10
`define PLL_INPUT_DIVIDER_FIELD_W 4
`define PLL_FEEDBACK_MULTIPLIER_FIELD_W 7
`define K2_W 7

// pll_config_reg field positions
`define PLL_BAND_LSB 0
`define PLL_REFSEL_BIT 2
`define PLL_BYP_BIT 3
`define PLL_PLL_INPUT_DIVIDER_FIELD_LSB 4
`define PLL_PLL_FEEDBACK_MULTIPLIER_FIELD_LSB 8
`define PLL_K2_LSB 16

// Status field positions
`define ST_SRC_LSB 0
`define ST_LOCK_BIT 2
`define ST_BUSY_BIT 3

// Reset values
`define RST_SRC 2'h0
`define RST_BAND 2'h0
`define RST_BYP 1'h1

// Numeric VCO: phase increment per 8 ns cycle, 24-bit phase
`define FW_W 24
`define FW_STEP 24'h000100
`define FW_B0_MIN 24'h19999A
`define FW_B0_MAX 24'h3851EC
`define FW_B1_MIN 24'h333333
`define FW_B1_MAX 24'h51EB85

`endif

// *** hw/clkgen_pkg.sv ***
package clkgen_pkg;

  // Clock source codes
  typedef enum logic [1:0] {
    SRC_WAKE = 2'b00,
    SRC_UNUSED = 2'b01,
    SRC_GEN = 2'b10,
    SRC_DIRECT = 2'b11
  } src_t;

  // Switch-over sequence
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_PARK = 2'b01,
    ST_WAIT = 2'b10
  } sw_state_t;

endpackage : clkgen_pkg

// *** hw/pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 4
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : pin_sync

// *** hw/clock_divider.sv ***
`timescale 1ns/100ps
module clock_divider #(
  parameter int W = 10
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic level_i,
  input wire logic rise_i,
  input wire logic [W-1:0] field_i,
  output logic level_o,
  output logic tick_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W:0] half;
  logic wrap;

  // Count source rising edges, wrap at field
  always_comb begin
    half = ({1'b0, field_i} + {{(W-1){1'b0}}, 2'b10}) >> 1;
    wrap = (cnt_q >= field_i);
    cnt_d = cnt_q;
    if (rise_i) begin
      cnt_d = wrap ? '0 : cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
    tick_o = rise_i && wrap;
    // Factor one passes the source level and its duty cycle
    if (field_i == '0) begin
      level_o = level_i;
    end else begin
      level_o = ({1'b0, cnt_q} < half);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : clock_divider

// *** hw/system_clock_generation.sv ***
`timescale 1ns/100ps
`include "clkgen_params.svh"
module system_clock_generation
  import clkgen_pkg::*;
#(
  parameter int PRE_W = `PRE_W,
  parameter int PLL_INPUT_DIVIDER_FIELD_W = `PLL_INPUT_DIVIDER_FIELD_W,
  parameter int PLL_FEEDBACK_MULTIPLIER_FIELD_W = `PLL_FEEDBACK_MULTIPLIER_FIELD_W,
  parameter int K2_W = `K2_W
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic oscillator_input_i,
  input wire logic external_clock_input_i,
  input wire logic internal_clock_i,
  input wire logic wakeup_clock_i,
  output logic system_clock_o,
  output logic pll_locked_o
);

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Rising edge of a synchronised level
  function automatic logic rise(input logic cur, input logic prev);
    return cur && !prev;
  endfunction : rise

  // Keep the VCO word inside its band
  function automatic logic [`FW_W-1:0] clamp(
    input logic [`FW_W-1:0] fw,
    input logic [1:0] band
  );
    logic [`FW_W-1:0] lo;
    logic [`FW_W-1:0] hi;
    lo = band[0] ? `FW_B1_MIN : `FW_B0_MIN;
    hi = band[0] ? `FW_B1_MAX : `FW_B0_MAX;
    if (fw < lo) begin
      return lo;
    end else if (fw > hi) begin
      return hi;
    end
    return fw;
  endfunction : clamp

  // Pin clocks pass two flops before use
  logic [3:0] pins_s;
  pin_sync #(
    .W(4)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i({wakeup_clock_i, internal_clock_i,
            external_clock_input_i, oscillator_input_i}),
    .sync_o(pins_s)
  );

  logic osc_s;
  logic ext_s;
  logic int_s;
  logic wu_s;
  assign osc_s = pins_s[0];
  assign ext_s = pins_s[1];
  assign int_s = pins_s[2];
  assign wu_s = pins_s[3];

  // Software-visible configuration
  logic [1:0] src_sel_q, src_sel_d;
  logic [1:0] band_q, band_d;
  logic ref_sel_q, ref_sel_d;
  logic vco_bypass_q, vco_bypass_d;
  logic [PLL_INPUT_DIVIDER_FIELD_W-1:0] pll_input_divider_field_q, pll_input_divider_field_d;
  logic [PLL_FEEDBACK_MULTIPLIER_FIELD_W-1:0] pll_feedback_multiplier_field_q, pll_feedback_multiplier_field_d;
  logic [K2_W-1:0] pll_output_divider_field_q, pll_output_divider_field_d;
  logic [PRE_W-1:0] prediv_q, prediv_d;
  logic pend_q, pend_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;

  // Settings in use by the clock path
  src_t act_src_q, act_src_d;
  logic act_ref_q, act_ref_d;
  logic act_byp_q, act_byp_d;
  logic [PLL_INPUT_DIVIDER_FIELD_W-1:0] act_p_q, act_p_d;
  logic [PLL_FEEDBACK_MULTIPLIER_FIELD_W-1:0] act_n_q, act_n_d;
  logic [K2_W-1:0] act_k2_q, act_k2_d;
  logic [PRE_W-1:0] act_pre_q, act_pre_d;
  logic [1:0] act_band_q, act_band_d;

  sw_state_t st_q, st_d;
  logic seen_low_q, seen_low_d;
  logic sysclk_q, sysclk_d;
  logic lock_q, lock_d;
  logic cand;
  logic [31:0] pll_word;
  logic [31:0] sys_word;
  logic [31:0] pre_word;
  logic [31:0] stat_word;
  logic [31:0] wv;
  logic req;

  always_comb begin
    sys_word = '0;
    sys_word[1:0] = src_sel_q;
    pll_word = '0;
    pll_word[`PLL_BAND_LSB +: 2] = band_q;
    pll_word[`PLL_REFSEL_BIT] = ref_sel_q;
    pll_word[`PLL_BYP_BIT] = vco_bypass_q;
    pll_word[`PLL_PLL_INPUT_DIVIDER_FIELD_LSB +: PLL_INPUT_DIVIDER_FIELD_W] = pll_input_divider_field_q;
    pll_word[`PLL_PLL_FEEDBACK_MULTIPLIER_FIELD_LSB +: PLL_FEEDBACK_MULTIPLIER_FIELD_W] = pll_feedback_multiplier_field_q;
    pll_word[`PLL_K2_LSB +: K2_W] = pll_output_divider_field_q;
    pre_word = '0;
    pre_word[PRE_W-1:0] = prediv_q;
    stat_word = '0;
    stat_word[`ST_SRC_LSB +: 2] = act_src_q;
    stat_word[`ST_LOCK_BIT] = lock_q;
    stat_word[`ST_BUSY_BIT] = pend_q || (st_q != ST_RUN);
  end

  // Wishbone slave: ack one cycle after request, unmapped reads zero
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !ack_q;
    ack_d = req;
    rdat_d = rdat_q;
    src_sel_d = src_sel_q;
    band_d = band_q;
    ref_sel_d = ref_sel_q;
    vco_bypass_d = vco_bypass_q;
    pll_input_divider_field_d = pll_input_divider_field_q;
    pll_feedback_multiplier_field_d = pll_feedback_multiplier_field_q;
    pll_output_divider_field_d = pll_output_divider_field_q;
    prediv_d = prediv_q;
    pend_d = pend_q;
    wv = '0;
    if (st_q == ST_PARK && !cand) begin
      pend_d = 1'b0;
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `OFS_SYS_CFG: rdat_d = sys_word;
        `OFS_PLL_CFG: rdat_d = pll_word;
        `OFS_PRE_CFG: rdat_d = pre_word;
        `OFS_STATUS: rdat_d = stat_word;
        default: rdat_d = '0;
      endcase
    end
    if (req && wb_we_i) begin
      unique case (wb_adr_i)
        `OFS_SYS_CFG: begin
          wv = merge(sys_word, wb_dat_i, wb_sel_i);
          src_sel_d = wv[1:0];
          pend_d = 1'b1; // A new write re-arms
        end
        `OFS_PLL_CFG: begin
          wv = merge(pll_word, wb_dat_i, wb_sel_i);
          if (!wv[`PLL_BAND_LSB + 1]) begin
            band_d = wv[`PLL_BAND_LSB +: 2]; // Reserved 1X ignored
          end
          ref_sel_d = wv[`PLL_REFSEL_BIT];
          vco_bypass_d = wv[`PLL_BYP_BIT];
          pll_input_divider_field_d = wv[`PLL_PLL_INPUT_DIVIDER_FIELD_LSB +: PLL_INPUT_DIVIDER_FIELD_W];
          pll_feedback_multiplier_field_d = wv[`PLL_PLL_FEEDBACK_MULTIPLIER_FIELD_LSB +: PLL_FEEDBACK_MULTIPLIER_FIELD_W];
          pll_output_divider_field_d = wv[`PLL_K2_LSB +: K2_W];
          pend_d = 1'b1;
        end
        `OFS_PRE_CFG: begin
          wv = merge(pre_word, wb_dat_i, wb_sel_i);
          prediv_d = wv[PRE_W-1:0];
          pend_d = 1'b1;
        end
        default: wv = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      src_sel_q <= `RST_SRC;
      band_q <= `RST_BAND;
      ref_sel_q <= 1'b0;
      vco_bypass_q <= `RST_BYP;
      pll_input_divider_field_q <= '0;
      pll_feedback_multiplier_field_q <= '0;
      pll_output_divider_field_q <= '0;
      prediv_q <= '0;
      pend_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      src_sel_q <= src_sel_d;
      band_q <= band_d;
      ref_sel_q <= ref_sel_d;
      vco_bypass_q <= vco_bypass_d;
      pll_input_divider_field_q <= pll_input_divider_field_d;
      pll_feedback_multiplier_field_q <= pll_feedback_multiplier_field_d;
      pll_output_divider_field_q <= pll_output_divider_field_d;
      prediv_q <= prediv_d;
      pend_q <= pend_d;
    end
  end

  // Reference for both prescaler and PLL
  logic ref_lvl;
  logic ref_prev_q;
  logic ref_rise;
  assign ref_lvl = act_ref_q ? int_s : osc_s;
  assign ref_rise = rise(ref_lvl, ref_prev_q);

  logic pre_lvl;
  clock_divider #(
    .W(PRE_W)
  ) u_prescale (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .level_i(ref_lvl),
    .rise_i(ref_rise),
    .field_i(act_pre_q), // Factor field+1, up to 1024
    .level_o(pre_lvl),
    .tick_o()
  );

  logic p_tick;
  clock_divider #(
    .W(PLL_INPUT_DIVIDER_FIELD_W)
  ) u_pll_input_divider_field (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .level_i(ref_lvl),
    .rise_i(ref_rise),
    .field_i(act_p_q), // Input divider P
    .level_o(),
    .tick_o(p_tick)
  );

  // Numeric VCO; limited by the 8 ns sample grid
  logic pll_en;
  logic [`FW_W-1:0] acc_q, acc_d;
  logic [`FW_W-1:0] fw_q, fw_d;
  logic [PLL_FEEDBACK_MULTIPLIER_FIELD_W+1:0] fbc_q, fbc_d;
  logic [PLL_FEEDBACK_MULTIPLIER_FIELD_W+1:0] nfac;
  logic vco_prev_q;
  logic vco_rise;
  assign pll_en = (act_src_q == SRC_GEN) && !act_byp_q;
  assign vco_rise = rise(acc_q[`FW_W-1], vco_prev_q);
  assign nfac = {2'b00, act_n_q} + {{(PLL_FEEDBACK_MULTIPLIER_FIELD_W+1){1'b0}}, 1'b1};

  // Frequency loop: N VCO edges per divided reference edge
  always_comb begin
    acc_d = pll_en ? acc_q + fw_q : '0;
    fw_d = fw_q;
    fbc_d = fbc_q;
    lock_d = pll_en ? lock_q : 1'b0;
    if (pll_en && vco_rise && (fbc_q != '1)) begin
      fbc_d = fbc_q + {{(PLL_FEEDBACK_MULTIPLIER_FIELD_W+1){1'b0}}, 1'b1};
    end
    if (pll_en && p_tick) begin
      fbc_d = vco_rise ? {{(PLL_FEEDBACK_MULTIPLIER_FIELD_W+1){1'b0}}, 1'b1} : '0; // Edge on the boundary opens the new window
      lock_d = (fbc_q == nfac);
      // One small step per compare, no jumps
      if (fbc_q < nfac) begin
        fw_d = fw_q + `FW_STEP;
      end else if (fbc_q > nfac) begin
        fw_d = fw_q - `FW_STEP;
      end
    end
    fw_d = clamp(fw_d, act_band_q); // Band limits
  end

  logic k2_lvl;
  clock_divider #(
    .W(K2_W)
  ) u_k2 (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .level_i(acc_q[`FW_W-1]),
    .rise_i(vco_rise),
    .field_i(act_k2_q), // K2 VCO cycles per output period
    .level_o(k2_lvl),
    .tick_o()
  );

  // Candidate clock from the active source
  always_comb begin
    unique case (act_src_q)
      SRC_WAKE: cand = wu_s;
      SRC_GEN: cand = act_byp_q ? pre_lvl : k2_lvl;
      SRC_DIRECT: cand = ext_s;
      default: cand = wu_s;
    endcase
  end

  // Switch-over: park low, load, resume on a new rising edge
  always_comb begin
    st_d = st_q;
    seen_low_d = seen_low_q;
    act_src_d = act_src_q;
    act_ref_d = act_ref_q;
    act_byp_d = act_byp_q;
    act_p_d = act_p_q;
    act_n_d = act_n_q;
    act_k2_d = act_k2_q;
    act_pre_d = act_pre_q;
    act_band_d = act_band_q;
    sysclk_d = cand;
    unique case (st_q)
      ST_RUN: begin
        if (pend_q) begin
          st_d = ST_PARK;
        end
      end
      ST_PARK: begin
        // Wait out the old high phase
        if (!cand) begin
          sysclk_d = 1'b0;
          act_src_d = src_t'(src_sel_q);
          act_ref_d = ref_sel_q;
          act_byp_d = vco_bypass_q;
          act_p_d = pll_input_divider_field_q;
          act_n_d = pll_feedback_multiplier_field_q;
          act_k2_d = pll_output_divider_field_q;
          act_pre_d = prediv_q;
          act_band_d = band_q;
          seen_low_d = 1'b0;
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Held low until the new clock rises after a low sample
        sysclk_d = 1'b0;
        if (!cand) begin
          seen_low_d = 1'b1;
        end else if (seen_low_q) begin
          sysclk_d = 1'b1;
          st_d = ST_RUN;
        end
      end
      default: begin
        sysclk_d = 1'b0;
        st_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_prev_q <= 1'b0;
      vco_prev_q <= 1'b0;
      acc_q <= '0;
      fw_q <= `FW_B0_MIN;
      fbc_q <= '0;
      lock_q <= 1'b0;
      st_q <= ST_RUN;
      seen_low_q <= 1'b0;
      sysclk_q <= 1'b0;
      act_src_q <= src_t'(`RST_SRC);
      act_ref_q <= 1'b0;
      act_byp_q <= `RST_BYP;
      act_p_q <= '0;
      act_n_q <= '0;
      act_k2_q <= '0;
      act_pre_q <= '0;
      act_band_q <= `RST_BAND;
    end else begin
      ref_prev_q <= ref_lvl;
      vco_prev_q <= acc_q[`FW_W-1];
      acc_q <= acc_d;
      fw_q <= fw_d;
      fbc_q <= fbc_d;
      lock_q <= lock_d;
      st_q <= st_d;
      seen_low_q <= seen_low_d;
      sysclk_q <= sysclk_d;
      act_src_q <= act_src_d;
      act_ref_q <= act_ref_d;
      act_byp_q <= act_byp_d;
      act_p_q <= act_p_d;
      act_n_q <= act_n_d;
      act_k2_q <= act_k2_d;
      act_pre_q <= act_pre_d;
      act_band_q <= act_band_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign system_clock_o = sysclk_q;
  assign pll_locked_o = lock_q;

endmodule : system_clock_generation

// *** dv/clkgen_chk.sv ***
`timescale 1ns/100ps
module clkgen_chk (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wakeup_clock_i,
  input wire logic system_clock_o
);
  logic [1:0] band_q;
  logic touched_q;
  logic wr_take;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

  // Shadow band and a flag for any clock setting write; reserved codes never land
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      band_q <= 2'h0;
      touched_q <= 1'b0;
    end else begin
      if (wr_take && wb_adr_i == 8'h04 && wb_sel_i[0] && !wb_dat_i[1]) band_q <= wb_dat_i[1:0];
      if (wr_take && wb_adr_i <= 8'h08) touched_q <= 1'b1;
    end
  end

  // Request steps on the bus
  sequence req_take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_take_s;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  endsequence

  ack_follow_a: assert property (req_take_s |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  rdata_hold_a: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (rd_take_s ##0 (wb_adr_i >= 8'h10) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  band_keep_a: assert property (rd_take_s ##0 (wb_adr_i == 8'h04) |=> wb_dat_o[1:0] == band_q)
    else $error("band field took a reserved code");
  // Three samples minimum: every source stays above that per level here
  high_width_a: assert property ($rose(system_clock_o) |-> system_clock_o[*3])
    else $error("short high pulse on system clock");
  low_width_a: assert property ($fell(system_clock_o) |-> (!system_clock_o)[*3])
    else $error("short low pulse on system clock");
  wake_follow_a: assert property (!touched_q |-> ##3 (touched_q || system_clock_o == $past(wakeup_clock_i, 3)))
    else $error("system clock not following wakeup source");
endmodule : clkgen_chk

// *** dv/source_clocks.sv ***
`timescale 1ns/100ps
module source_clocks #(
  parameter int OSC_NS = 64,
  parameter int EXT_NS = 80,
  parameter int INT_NS = 136,
  parameter int WAKE_NS = 400
) (
  output logic oscillator_input_o,
  output logic external_clock_input_o,
  output logic internal_clock_o,
  output logic wakeup_clock_o
);
  // Free-running sources, offset so no edge meets the system clock edge
  initial begin
    oscillator_input_o = 1'b0;
    external_clock_input_o = 1'b0;
    internal_clock_o = 1'b0;
    wakeup_clock_o = 1'b0;
    #3.3;
    fork
      forever #(OSC_NS / 2) oscillator_input_o = ~oscillator_input_o;
      forever #(EXT_NS / 2) external_clock_input_o = ~external_clock_input_o;
      forever #(INT_NS / 2) internal_clock_o = ~internal_clock_o;
      forever #(WAKE_NS / 2) wakeup_clock_o = ~wakeup_clock_o;
    join
  end
endmodule : source_clocks

// *** dv/testbench.sv ***
`timescale 1ns/100ps
`include "clkgen_params.svh"
module testbench import clkgen_pkg::*;;
  logic clk_sys_i, arst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic osc, ext, intc, wake, sys_clk, locked;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  // Prescaler cases: field, pll setting, periods, expected cycles and high cycles
  logic [31:0] pre_f [4] = '{32'h0, 32'h3, 32'h1, 32'h3FF};
  logic [31:0] pre_c [4] = '{32'h8, 32'h8, 32'hC, 32'h8};
  int pre_n [4] = '{8, 4, 4, 1};
  int pre_p [4] = '{64, 128, 136, 8192};
  int pre_h [4] = '{32, 64, 68, 4096};

  system_clock_generation i_system_clock_generation (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .oscillator_input_i(osc),
    .external_clock_input_i(ext), .internal_clock_i(intc), .wakeup_clock_i(wake),
    .system_clock_o(sys_clk), .pll_locked_o(locked));
  source_clocks i_source_clocks (.oscillator_input_o(osc), .external_clock_input_o(ext),
    .internal_clock_o(intc), .wakeup_clock_o(wake));

  task automatic stop_test;
    $display("Counts: compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_per(input int got, input int exp, input int tol);
    compares++;
    if (got > exp + tol || got < exp - tol) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_per

  // One classic cycle; request held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] sel,
                         output logic [31:0] rd);
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= sel;
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] rd;
    wb_xfer(1'b1, adr, wd, 4'hF, rd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, adr, 32'h0, 4'hF, rd);
    check_val(rd & mask, exp);
  endtask : rd_chk

  // Switch-over time depends on the sources, so poll busy
  task automatic wait_idle;
    logic [31:0] rd;
    do wb_xfer(1'b0, `OFS_STATUS, 32'h0, 4'hF, rd); while (rd[3] !== 1'b0);
  endtask : wait_idle

  // Cycles and high cycles over n whole output periods
  task automatic measure(input int n, output int per, output int hi);
    int k;
    logic last;
    k = -1;
    per = 0;
    hi = 0;
    last = 1'b1;
    while (k < n) begin
      @(posedge clk_sys_i);
      if (sys_clk === 1'b1 && last === 1'b0) k++;
      if (k >= 0 && k < n) begin
        per++;
        if (sys_clk === 1'b1) hi++;
      end
      last = sys_clk;
    end
  endtask : measure

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard, sized above the slowest divider and PLL settling
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 95000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    int per, hi, prev, tries;
    logic [31:0] rdv;
    arst_n_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    repeat (4) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd_chk(`OFS_SYS_CFG, 32'hFFFF_FFFF, 32'h0);
    rd_chk(`OFS_PLL_CFG, 32'hFFFF_FFFF, 32'h8);
    rd_chk(`OFS_PRE_CFG, 32'hFFFF_FFFF, 32'h0);
    wr(`OFS_STATUS, 32'hF);
    rd_chk(`OFS_STATUS, 32'hB, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'hFFFF_FFFF, 32'h0);
    measure(4, per, hi);
    check_per(per, 200, 2);
    $display("Test reset and wakeup done");
    wr(`OFS_SYS_CFG, {30'h0, SRC_DIRECT});
    wait_idle();
    rd_chk(`OFS_STATUS, 32'h3, 32'h3);
    measure(8, per, hi);
    check_per(per, 80, 2);
    check_per(hi, 40, 2);
    $display("Test direct drive done");
    // Divider and reference first, source last
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_PRE_CFG, pre_f[i]);
      wr(`OFS_PLL_CFG, pre_c[i]);
      wr(`OFS_SYS_CFG, {30'h0, SRC_GEN});
      wait_idle();
      measure(pre_n[i], per, hi);
      check_per(per, pre_p[i], 2);
      check_per(hi, pre_h[i], 2);
    end
    $display("Test prescaler done");
    // P=5, N=4, K2=2 on the oscillator: VCO sits on the band floor, so the slow loop settles in the run
    wr(`OFS_PLL_CFG, 32'h0001_0340);
    wait_idle();
    rd_chk(`OFS_PLL_CFG, 32'hFFFF_FFFF, 32'h0001_0340);
    measure(10, prev, hi);
    tries = 0;
    // Each compare may nudge the VCO; the period must never jump
    do begin
      measure(10, per, hi);
      check_per(per, prev, 3);
      prev = per;
      tries++;
    end while ((locked !== 1'b1 || per > 201 || per < 199) && tries < 150);
    check_per(per, 200, 1);
    check_val({31'h0, locked}, 32'h1);
    $display("Test pll done");
    wb_xfer(1'b1, `OFS_PLL_CFG, 32'hFFFF_FF19, 4'h1, rdv);
    rd_chk(`OFS_PLL_CFG, 32'hFFFF_FFFF, 32'h0001_0319);
    wr(`OFS_PLL_CFG, 32'h0001_041A);
    rd_chk(`OFS_PLL_CFG, 32'hFFFF_FFFF, 32'h0001_0419);
    $display("Test band done");
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd_chk(`OFS_PLL_CFG, 32'hFFFF_FFFF, 32'h8);
    rd_chk(`OFS_STATUS, 32'h3, 32'h0);
    measure(2, per, hi);
    check_per(per, 100, 2);
    $display("Test second reset done");
    stop_test();
  end
endmodule : testbench

bind system_clock_generation clkgen_chk i_clkgen_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wakeup_clock_i(wakeup_clock_i),
  .system_clock_o(system_clock_o));
